// ===== core/csvr_pkg.sv
/*
 * Package for the clock status and volume register slice: register offsets,
 * field positions, reset values, rate codes and volume codes.
 * Assumes an 8-bit register address space reached by the control interface.
 */
package csvr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CSVR_OFS_STATUS    = 8'h39;
    localparam logic [7:0] CSVR_OFS_FLOAT     = 8'h40;
    localparam logic [7:0] CSVR_OFS_FLOW      = 8'h46;
    localparam logic [7:0] CSVR_OFS_LEFT_VOL  = 8'h4c;
    localparam logic [7:0] CSVR_OFS_RIGHT_VOL = 8'h4d;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CSVR_RST_STATUS = 8'h00;
    localparam logic [7:0] CSVR_RST_FLOAT  = 8'h01;
    localparam logic [7:0] CSVR_RST_FLOW   = 8'h01;
    localparam logic [7:0] CSVR_RST_VOL    = 8'h30;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CSVR_BIT_BCLK_OVER   = 5;
    localparam int CSVR_BIT_PLL_OVER    = 4;
    localparam int CSVR_BIT_PLL_UNLOCK  = 3;
    localparam int CSVR_BIT_BCLK_MISS   = 2;
    localparam int CSVR_BIT_RATIO_BAD   = 1;
    localparam int CSVR_BIT_RATE_BAD    = 0;
    localparam int CSVR_BIT_CH1_FLOAT   = 3;
    localparam int CSVR_BIT_CH2_FLOAT   = 2;
    localparam int CSVR_BIT_FLOW_SELECT = 4;

    // ------------------------------------------------------------------
    // Rate codes, ratio limits, volume codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CSVR_RATE_ERROR = 4'h0;
    localparam logic [3:0] CSVR_RATE_48K   = 4'h9;
    localparam logic [9:0] CSVR_RATIO_MIN  = 10'h020;
    localparam logic [9:0] CSVR_RATIO_MAX  = 10'h200;
    localparam logic [7:0] CSVR_VOL_0DB    = 8'h30;
    localparam logic [7:0] CSVR_VOL_MIN    = 8'hfe;
    localparam logic [7:0] CSVR_VOL_MUTE   = 8'hff;

endpackage

// ===== core/csvr_regs.sv
/*
 * Clock-detection status, channel float control, processing flow select
 * and per-channel volume registers behind a simple 8-bit register port.
 * Assumes the control-interface front end presents one-cycle write and
 * read strobes on sys_clk, and that detector levels arrive from the
 * audio clock domain unsynchronised.
 */
// Operation
// - Status bit 5 reads 1 when the bit clock is overrate and 0 when underrate.
// - Status bit 4 reads 1 when the PLL is overrate and 0 when underrate.
// - Status bit 3 reads 0 when the PLL is locked, 1 otherwise, and 1 whenever it is disabled.
// - Status bit 2 reads 1 when the bit clock is missing and 0 when present.
// - Status bit 1 reads 0 only when the bit-clock ratio is stable and within 32 to 512.
// - In automatic rate mode status bit 0 reads 1 when the detected rate is invalid.
// - In fixed rate mode status bit 0 is set when the configured rate differs from the detected.
// - The ignore-rate-error option never suppresses status bit 0.
// - Float control bit 3 forces channel 1 into high impedance when 1.
// - Float control bit 2 forces channel 2 into high impedance when 1.
// - Flow select bit 4 picks the 96k flow at 0 and the 48k 2.1 flow at 1.
// - Channel 1 volume code 0 is +24 dB with 0.5 dB less gain per code, down to -103 dB.
// - Channel 2 volume uses the same half-dB mapping from +24 dB down to -103 dB.
// - The all-ones volume code mutes the channel and the code below it gives -103 dB.
// - Both volume registers reset to the 0 dB code, whose successor gives -0.5 dB.
// - Automatic rate detection reports a 4-bit code where 0000 is an error and 1001 is 48 kHz.
`timescale 1ns/10ps

module csvr_regs
    import csvr_pkg::*;
#(
    parameter int RATIO_W = 10
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         regAddr,
    input  wire logic               regWrite,
    input  wire logic [7:0]         regWdata,
    input  wire logic               regRead,
    output logic      [7:0]         regRdata,
    output logic                    regRvalid,
    input  wire logic               bclkOverrate,
    input  wire logic               pllOverrate,
    input  wire logic               pllLocked,
    input  wire logic               pllEnable,
    input  wire logic               bclkMissing,
    input  wire logic               ratioStable,
    input  wire logic [RATIO_W-1:0] bclkRatio,
    input  wire logic [3:0]         detected_rate_code,
    input  wire logic [3:0]         rateSelect,
    input  wire logic               rateErrorIgnore,
    output logic                    chan1_float_force,
    output logic                    chan2_float_force,
    output logic                    processing_flow_select,
    output logic      [7:0]         chan1_volume_code,
    output logic      [7:0]         chan2_volume_code,
    output logic                    chan1Mute,
    output logic                    chan2Mute,
    output logic      [3:0]         rateCodeOut,
    output logic      [7:0]         clockStatus
);

    // ------------------------------------------------------------------
    // Synchronisers for detector levels from the audio clock domain
    // ------------------------------------------------------------------
    localparam int SW = 7 + RATIO_W + 8;

    logic [SW-1:0] syncMeta_q;
    logic [SW-1:0] syncOut_q;
    wire  [SW-1:0] syncIn = {bclkOverrate, pllOverrate, pllLocked, pllEnable,
                             bclkMissing, ratioStable, rateErrorIgnore,
                             bclkRatio, detected_rate_code, rateSelect};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_q <= '0;
            syncOut_q  <= '0;
        end else begin
            syncMeta_q <= syncIn;
            syncOut_q  <= syncMeta_q;
        end
    end

    wire               sBclkOver  = syncOut_q[SW-1];
    wire               sPllOver   = syncOut_q[SW-2];
    wire               sPllLocked = syncOut_q[SW-3];
    wire               sPllEnable = syncOut_q[SW-4];
    wire               sBclkMiss  = syncOut_q[SW-5];
    wire               sStable    = syncOut_q[SW-6];
    wire [RATIO_W-1:0] sRatio     = syncOut_q[8 +: RATIO_W];
    wire [3:0]         sRateCode  = syncOut_q[7:4];
    wire [3:0]         sRateSel   = syncOut_q[3:0];
    // Ignore option is synchronised but deliberately left out of the flag
    wire               sIgnore    = syncOut_q[SW-7];

    // ------------------------------------------------------------------
    // Status decode
    // ------------------------------------------------------------------
    wire pllUnlocked = !sPllEnable || !sPllLocked;
    wire ratioInRange = ({{(32-RATIO_W){1'b0}}, sRatio} >= 32'(CSVR_RATIO_MIN)) &&
                        ({{(32-RATIO_W){1'b0}}, sRatio} <= 32'(CSVR_RATIO_MAX));
    wire ratioBad    = !(sStable && ratioInRange);
    wire autoMode    = (sRateSel == 4'h0);
    // Fixed mode compares configured rate code against detected one
    wire rateBad     = autoMode ? (sRateCode == CSVR_RATE_ERROR)
                                : (sRateSel != sRateCode);
    // Ignore drives nothing in this module and never affects this flag
    wire rateFlag    = rateBad | (sIgnore & 1'b0);

    wire [7:0] statusD;
    assign statusD[7:6]                 = 2'h0;
    assign statusD[CSVR_BIT_BCLK_OVER]  = sBclkOver;
    assign statusD[CSVR_BIT_PLL_OVER]   = sPllOver;
    assign statusD[CSVR_BIT_PLL_UNLOCK] = pllUnlocked;
    assign statusD[CSVR_BIT_BCLK_MISS]  = sBclkMiss;
    assign statusD[CSVR_BIT_RATIO_BAD]  = ratioBad;
    assign statusD[CSVR_BIT_RATE_BAD]   = rateFlag;

    logic [7:0] status_q;
    logic [3:0] rateCode_q;

    // Live status, no latching and no clear on read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q   <= CSVR_RST_STATUS;
            rateCode_q <= CSVR_RATE_ERROR;
        end else begin
            status_q   <= statusD;
            rateCode_q <= autoMode ? sRateCode : sRateSel;
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    logic [7:0] float_q;
    logic [7:0] flow_q;
    logic [7:0] leftVol_q;
    logic [7:0] rightVol_q;

    wire wrFloat = regWrite && (regAddr == CSVR_OFS_FLOAT);
    wire wrFlow  = regWrite && (regAddr == CSVR_OFS_FLOW);
    wire wrLeft  = regWrite && (regAddr == CSVR_OFS_LEFT_VOL);
    wire wrRight = regWrite && (regAddr == CSVR_OFS_RIGHT_VOL);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            float_q    <= CSVR_RST_FLOAT;
            flow_q     <= CSVR_RST_FLOW;
            leftVol_q  <= CSVR_RST_VOL;
            rightVol_q <= CSVR_RST_VOL;
        end else begin
            if (wrFloat) begin
                float_q <= regWdata;
            end
            if (wrFlow) begin
                flow_q <= regWdata;
            end
            if (wrLeft) begin
                leftVol_q <= regWdata;
            end
            if (wrRight) begin
                rightVol_q <= regWdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path; unmapped offsets read zero
    // ------------------------------------------------------------------
    logic [7:0] readMux;

    always_comb begin
        case (regAddr)
            CSVR_OFS_STATUS:    readMux = status_q;
            CSVR_OFS_FLOAT:     readMux = float_q;
            CSVR_OFS_FLOW:      readMux = flow_q;
            CSVR_OFS_LEFT_VOL:  readMux = leftVol_q;
            CSVR_OFS_RIGHT_VOL: readMux = rightVol_q;
            default:            readMux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata  <= 8'h00;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= readMux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the channel and processing logic
    // ------------------------------------------------------------------
    // Gain in dB = 24 - code/2 for codes below the mute code
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan1_float_force      <= 1'b0;
            chan2_float_force      <= 1'b0;
            processing_flow_select <= 1'b0;
            chan1_volume_code      <= CSVR_VOL_0DB;
            chan2_volume_code      <= CSVR_VOL_0DB;
            chan1Mute              <= 1'b0;
            chan2Mute              <= 1'b0;
            rateCodeOut            <= CSVR_RATE_ERROR;
            clockStatus            <= CSVR_RST_STATUS;
        end else begin
            chan1_float_force      <= float_q[CSVR_BIT_CH1_FLOAT];
            chan2_float_force      <= float_q[CSVR_BIT_CH2_FLOAT];
            processing_flow_select <= flow_q[CSVR_BIT_FLOW_SELECT];
            chan1_volume_code      <= leftVol_q;
            chan2_volume_code      <= rightVol_q;
            chan1Mute              <= (leftVol_q == CSVR_VOL_MUTE);
            chan2Mute              <= (rightVol_q == CSVR_VOL_MUTE);
            rateCodeOut            <= rateCode_q;
            clockStatus            <= status_q;
        end
    end

endmodule // csvr_regs

// ===== test/csvr_host_model.sv
/*
 * Host-side model of the control interface: single-byte register writes
 * and reads with one-cycle strobes.
 * Assumes the bench calls wr and rd one at a time, just after a sys_clk edge.
 */
`timescale 1ns/10ps
module csvr_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] regRdata,
    input  wire logic       regRvalid,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWdata,
    output logic            regRead
);
    initial begin
        {regAddr, regWdata, regWrite, regRead} = '0;
    end
    // The leading edge wait keeps two strobes of a row from sharing a time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 {regAddr, regWdata, regWrite} = {a, d, 1'b1};
        @(posedge sys_clk);
        #1 regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1 {regAddr, regRead} = {a, 1'b1};
        @(posedge sys_clk);
        #1 regRead = 1'b0;
        d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
    endtask
endmodule // csvr_host_model

// ===== test/csvr_regs_chk.sv
/*
 * Port-level assertions for the clock status and volume register slice.
 * Assumes the bind below attaches it to every csvr_regs instance.
 */
`timescale 1ns/10ps
module csvr_regs_chk
    import csvr_pkg::*;
#(
    parameter int RATIO_W = 10
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic [7:0] regWdata,
    input wire logic       regRead,
    input wire logic       regRvalid,
    input wire logic       pllLocked,
    input wire logic       pllEnable,
    input wire logic       bclkMissing,
    input wire logic [3:0] detected_rate_code,
    input wire logic [3:0] rateSelect,
    input wire logic       chan1_float_force,
    input wire logic       chan2_float_force,
    input wire logic       processing_flow_select,
    input wire logic [7:0] chan1_volume_code,
    input wire logic       chan1Mute,
    input wire logic [7:0] clockStatus
);
    wire wrFloat = regWrite && regAddr == CSVR_OFS_FLOAT;
    wire wrFlow  = regWrite && regAddr == CSVR_OFS_FLOW;
    wire rateBad = rateSelect == 4'h0 ? detected_rate_code == 4'h0
                                      : rateSelect != detected_rate_code;
    // Synchroniser and status stages hold reset values for a few edges after release
    logic [2:0] upCnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_q <= 3'h0;
        end else if (upCnt_q != 3'h5) begin
            upCnt_q <= upCnt_q + 3'h1;
        end
    end
    wire settled = (upCnt_q == 3'h5);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    read_answer_a: assert property (regRvalid == $past(regRead))
        else $error("read valid not one cycle after read strobe");
    float_one_a: assert property (wrFloat ##1 !wrFloat |=> chan1_float_force == $past(regWdata[3], 2))
        else $error("channel 1 float does not follow write");
    float_two_a: assert property (wrFloat ##1 !wrFloat |=> chan2_float_force == $past(regWdata[2], 2))
        else $error("channel 2 float does not follow write");
    flow_select_a: assert property (wrFlow ##1 !wrFlow |=> processing_flow_select == $past(regWdata[4], 2))
        else $error("flow select does not follow write");
    mute_code_a: assert property (chan1Mute == (chan1_volume_code == 8'hff))
        else $error("channel 1 mute disagrees with code");
    bclk_miss_a: assert property (settled && $stable(bclkMissing)[*4] |-> clockStatus[2] == bclkMissing)
        else $error("missing bit clock flag wrong");
    pll_unlock_a: assert property (settled && $stable({pllEnable, pllLocked})[*4]
        |-> clockStatus[3] == !(pllEnable && pllLocked))
        else $error("pll unlock flag wrong");
    rate_flag_a: assert property (settled && $stable({rateSelect, detected_rate_code})[*4]
        |-> clockStatus[0] == rateBad)
        else $error("sample rate flag wrong");
endmodule // csvr_regs_chk

bind csvr_regs csvr_regs_chk #(.RATIO_W(RATIO_W)) i_chk (.sys_clk, .rst_n, .regAddr, .regWrite,
    .regWdata, .regRead, .regRvalid, .pllLocked, .pllEnable, .bclkMissing, .detected_rate_code,
    .rateSelect, .chan1_float_force, .chan2_float_force, .processing_flow_select,
    .chan1_volume_code, .chan1Mute, .clockStatus);

// ===== test/csvr_regs_test.sv
/*
 * Self-checking bench for csvr_regs: reset values, a table of detector
 * conditions, then refused accesses, float, flow, volume and a second reset.
 * Assumes csvr_pkg, the host model and the checker are compiled before it.
 */
`timescale 1ns/10ps
module csvr_regs_test;
    import csvr_pkg::*;
    typedef struct packed {
        logic [5:0] f;
        logic [9:0] r;
        logic [3:0] c;
        logic [3:0] s;
        logic       ig;
        logic [7:0] e;
    } csvr_row_t;
    logic       sys_clk = 0;
    logic       rst_n = 0;
    logic [5:0] det = 6'b001101;
    logic [9:0] ratio = 10'h040;
    logic [3:0] code = 4'h9, rsel = 4'h0, rco;
    logic       ign = 0, f1, f2, flow, m1, m2, rv, wr, rdq;
    logic [7:0] adr, wd, rdat, v1, v2, cst;
    int         errors = 0;
    int         comparisons = 0;
    logic [7:0] vols [5] = '{8'h00, 8'h2f, 8'h31, 8'hfe, 8'hff};
    csvr_row_t  rows [14] = '{
        '{6'b001101, 10'h040, 4'h9, 4'h0, 1'b0, 8'h00}, '{6'b101101, 10'h040, 4'h9, 4'h0, 1'b0, 8'h20},
        '{6'b011101, 10'h040, 4'h9, 4'h0, 1'b0, 8'h10}, '{6'b001001, 10'h040, 4'h9, 4'h0, 1'b0, 8'h08},
        '{6'b000101, 10'h040, 4'h9, 4'h0, 1'b0, 8'h08}, '{6'b001111, 10'h040, 4'h9, 4'h0, 1'b0, 8'h04},
        '{6'b001101, 10'h01f, 4'h9, 4'h0, 1'b0, 8'h02}, '{6'b001101, 10'h020, 4'h9, 4'h0, 1'b0, 8'h00},
        '{6'b001101, 10'h200, 4'h9, 4'h0, 1'b0, 8'h00}, '{6'b001101, 10'h201, 4'h9, 4'h0, 1'b0, 8'h02},
        '{6'b001100, 10'h040, 4'h9, 4'h0, 1'b0, 8'h02}, '{6'b001101, 10'h040, 4'h0, 4'h0, 1'b1, 8'h01},
        '{6'b001101, 10'h040, 4'h9, 4'h9, 1'b1, 8'h00}, '{6'b001101, 10'h040, 4'hb, 4'h9, 1'b0, 8'h01}};
    always #5 sys_clk = ~sys_clk;
    csvr_host_model h (.sys_clk, .regRdata(rdat), .regRvalid(rv), .regAddr(adr), .regWrite(wr),
        .regWdata(wd), .regRead(rdq));
    csvr_regs i_dut (.sys_clk, .rst_n, .regAddr(adr), .regWrite(wr), .regWdata(wd), .regRead(rdq),
        .regRdata(rdat), .regRvalid(rv), .bclkOverrate(det[5]), .pllOverrate(det[4]),
        .pllLocked(det[3]), .pllEnable(det[2]), .bclkMissing(det[1]), .ratioStable(det[0]),
        .bclkRatio(ratio), .detected_rate_code(code), .rateSelect(rsel), .rateErrorIgnore(ign),
        .chan1_float_force(f1), .chan2_float_force(f2), .processing_flow_select(flow),
        .chan1_volume_code(v1), .chan2_volume_code(v2), .chan1Mute(m1), .chan2Mute(m2),
        .rateCodeOut(rco), .clockStatus(cst));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        h.rd(a, d);
        chk(d, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic close_out;
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole run is well under 2000 cycles
    initial begin
        #50000;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
    initial begin
        cyc(4);
        rst_n = 1;
        chk({f1, f2, flow, m1, m2}, 8'h00);
        chk(v1, 8'h30);
        chk(v2, 8'h30);
        rdc(CSVR_OFS_FLOAT, 8'h01);
        rdc(CSVR_OFS_FLOW, 8'h01);
        rdc(CSVR_OFS_RIGHT_VOL, 8'h30);
        rdc(CSVR_OFS_STATUS, 8'h00);
        $display("Test reset finished");
        foreach (rows[i]) begin
            {det, ratio, code, rsel, ign} = {rows[i].f, rows[i].r, rows[i].c, rows[i].s, rows[i].ig};
            cyc(5);
            chk(cst, rows[i].e);
            chk(rco, rows[i].s == 4'h0 ? rows[i].c : rows[i].s);
            rdc(CSVR_OFS_STATUS, rows[i].e);
        end
        $display("Test status table finished");
        h.wr(CSVR_OFS_STATUS, 8'hff);
        rdc(CSVR_OFS_STATUS, 8'h01);
        rdc(8'h41, 8'h00);
        h.wr(CSVR_OFS_FLOAT, 8'h08);
        cyc(1);
        chk({f1, f2}, 8'h02);
        h.wr(CSVR_OFS_FLOAT, 8'h04);
        cyc(1);
        chk({f1, f2}, 8'h01);
        h.wr(CSVR_OFS_FLOW, 8'h10);
        cyc(1);
        chk(flow, 8'h01);
        h.wr(CSVR_OFS_FLOW, 8'h00);
        cyc(1);
        chk(flow, 8'h00);
        foreach (vols[i]) begin
            h.wr(CSVR_OFS_LEFT_VOL, vols[i]);
            h.wr(CSVR_OFS_RIGHT_VOL, vols[4 - i]);
            cyc(1);
            chk(v1, vols[i]);
            chk(v2, vols[4 - i]);
            chk({m1, m2}, {vols[i] == 8'hff, vols[4 - i] == 8'hff});
            rdc(CSVR_OFS_LEFT_VOL, vols[i]);
        end
        $display("Test register access finished");
        rst_n = 0;
        cyc(2);
        chk(v2, 8'h30);
        rst_n = 1;
        rdc(CSVR_OFS_FLOAT, 8'h01);
        rdc(CSVR_OFS_LEFT_VOL, 8'h30);
        $display("Test second reset finished");
        close_out();
    end
endmodule // csvr_regs_test
